//--- cra_pkg.sv
// constants, encodings and carrier types of the core register set
package cra_pkg;
    localparam int          DW          = 8;
    localparam int          AW          = 12;
    localparam int          IDX_SEL_BIT = 11;
    localparam logic [11:0] ADR_IDX_HI  = 12'h0BE;
    localparam logic [11:0] ADR_IDX_LO  = 12'h0BF;
    localparam logic [11:0] ADR_STK_TOP = 12'h0FE;
    localparam logic [11:0] ADR_FLAGS   = 12'h0FF;
    localparam logic [11:0] PC_RST_ADDR = 12'h800;
    localparam logic [3:0]  STK_RST     = 4'hF;
    localparam logic [3:0]  STK_PAGE    = 4'h3;
    localparam logic [3:0]  STK_STEP    = 4'h2;
    localparam logic [7:0]  REL_MIN     = 8'hE1;
    localparam logic [7:0]  REL_MAX     = 8'h20;

    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_LOAD_A     = 4'h1,
        OP_STORE_A    = 4'h2,
        OP_LOAD_X     = 4'h3,
        OP_INC_X      = 4'h4,
        OP_DEC_X      = 4'h5,
        OP_SHORT_JUMP = 4'h6,
        OP_LONG_JUMP  = 4'h7,
        OP_CALL       = 4'h8,
        OP_RETURN     = 4'h9
    } cra_op_e;

    typedef enum logic [2:0] {
        MODE_INHERENT  = 3'h0,
        MODE_IMMEDIATE = 3'h1,
        MODE_DIRECT    = 3'h2,
        MODE_INDEXED   = 3'h3,
        MODE_INDIRECT  = 3'h4
    } cra_mode_e;

    typedef enum logic [2:0] {
        ST_IDLE      = 3'b000,
        ST_LOAD_WAIT = 3'b001,
        ST_PUSH_HI   = 3'b010,
        ST_PULL_HI   = 3'b100,
        ST_PULL_LO   = 3'b101
    } cra_state_e;

    typedef struct packed {
        logic      valid;
        cra_op_e   op;
        cra_mode_e mode;
        logic [1:0] len;
        logic [7:0] opHi;
        logic [7:0] opLo;
    } cra_cmd_s;

    typedef struct packed {
        logic       re;
        logic       we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } cra_mem_s;
endpackage : cra_pkg

//--- cra_core_regs.sv
// programmer-visible registers, stack and operand address generation
`timescale 1ns/1ps
module cra_core_regs
    import cra_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst,
    input  wire cra_cmd_s   cmd,
    input  wire logic [7:0] memRdata,
    output cra_mem_s        memReq,
    output logic            busy,
    output logic [7:0]      accOut,
    output logic [11:0]     indexOut,
    output logic [11:0]     nextInstAddr,
    output logic [3:0]      stackTopIdx,
    output logic [7:0]      condFlagsOut
);
    cra_state_e  state_r;
    cra_state_e  state_nxt;
    cra_mem_s    memReq_r;
    logic        busy_r;
    logic [7:0]  acc_r;
    logic [11:0] index_r;
    logic [11:0] nextInstPtr_r;
    logic [3:0]  stackTop_r;
    logic [7:0]  condFlags_r;
    logic [10:0] retHold_r;
    logic        accept;
    logic        isMemMode;
    logic        regHit;
    logic        memRead;
    logic        storeReg;
    logic        relOk;
    logic [11:0] ea;
    logic [7:0]  regRdata;
    logic [10:0] seqPc;
    logic [10:0] relPc;
    logic [10:0] absTarget;

    // stack slot address inside the 0x30-0x3F page
    function automatic logic [11:0] stkAddr(input logic [3:0] idx);
        stkAddr = {4'h0, STK_PAGE, idx};
    endfunction : stkAddr

    // effective address and mapped-register decode
    always_comb
    begin
        accept    = cmd.valid && (state_r == ST_IDLE);
        isMemMode = (cmd.mode == MODE_DIRECT) || (cmd.mode == MODE_INDEXED) || (cmd.mode == MODE_INDIRECT);
        ea        = 12'h000;
        if (cmd.mode == MODE_INDEXED)
        begin
            ea = {index_r[IDX_SEL_BIT], index_r[10:0] + {3'h0, cmd.opLo}};
        end
        else if (cmd.mode == MODE_INDIRECT)
        begin
            ea = index_r;
        end
        else if (cmd.mode == MODE_DIRECT)
        begin
            ea = {4'h0, cmd.opLo};
        end
        regHit   = isMemMode && ((ea == ADR_IDX_HI) || (ea == ADR_IDX_LO) || (ea == ADR_STK_TOP) || (ea == ADR_FLAGS));
        regRdata = 8'h00;
        if (ea == ADR_IDX_HI)
        begin
            regRdata = {5'h00, index_r[10:8]};
        end
        else if (ea == ADR_IDX_LO)
        begin
            regRdata = index_r[7:0];
        end
        else if (ea == ADR_STK_TOP)
        begin
            regRdata = {4'h0, stackTop_r};
        end
        else if (ea == ADR_FLAGS)
        begin
            regRdata = condFlags_r;
        end
        memRead   = accept && (cmd.op == OP_LOAD_A) && isMemMode && !regHit;
        storeReg  = accept && (cmd.op == OP_STORE_A) && regHit;
        seqPc     = nextInstPtr_r[10:0] + {9'h000, cmd.len};
        relOk     = ($signed(cmd.opLo) >= $signed(REL_MIN)) && ($signed(cmd.opLo) <= $signed(REL_MAX));
        relPc     = nextInstPtr_r[10:0] + {{3{cmd.opLo[7]}}, cmd.opLo};
        absTarget = {cmd.opHi[2:0], cmd.opLo};
    end

    // sequencer for reads and stack transfers
    always_comb
    begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE:
            begin
                if (memRead)
                    state_nxt = ST_LOAD_WAIT;
                else if (accept && (cmd.op == OP_CALL))
                    state_nxt = ST_PUSH_HI;
                else if (accept && (cmd.op == OP_RETURN))
                    state_nxt = ST_PULL_HI;
            end
            ST_PULL_HI: state_nxt = ST_PULL_LO;
            default:    state_nxt = ST_IDLE;
        endcase
    end

    // state and busy flag
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            state_r <= ST_IDLE;
            busy_r  <= 1'b0;
        end
        else
        begin
            state_r <= state_nxt;
            busy_r  <= (state_nxt != ST_IDLE);
        end
    end

    // memory request, one cycle per strobe
    always_ff @(posedge mclk)
    begin
        if (rst)
            memReq_r <= '0;
        else
        begin
            memReq_r <= '0;
            if (memRead)
            begin
                memReq_r.re   <= 1'b1;
                memReq_r.addr <= ea;
            end
            else if (accept && (cmd.op == OP_STORE_A) && isMemMode && !regHit && !ea[IDX_SEL_BIT])
            begin
                memReq_r.we    <= 1'b1;
                memReq_r.addr  <= ea;
                memReq_r.wdata <= acc_r;
            end
            else if (accept && (cmd.op == OP_CALL))
            begin
                memReq_r.we    <= 1'b1;
                memReq_r.addr  <= stkAddr(stackTop_r);
                memReq_r.wdata <= seqPc[7:0];
            end
            else if (accept && (cmd.op == OP_RETURN))
            begin
                memReq_r.re   <= 1'b1;
                memReq_r.addr <= stkAddr(stackTop_r + 4'h1);
            end
            else if (state_r == ST_PUSH_HI)
            begin
                memReq_r.we    <= 1'b1;
                memReq_r.addr  <= stkAddr(stackTop_r - 4'h1);
                memReq_r.wdata <= {5'h00, retHold_r[10:8]};
            end
            else if (state_r == ST_PULL_HI)
            begin
                memReq_r.re   <= 1'b1;
                memReq_r.addr <= stkAddr(stackTop_r + STK_STEP);
            end
        end
    end

    // working register loads
    always_ff @(posedge mclk)
    begin
        if (rst)
            acc_r <= 8'h00;
        else if (accept && (cmd.op == OP_LOAD_A) && (cmd.mode == MODE_IMMEDIATE))
            acc_r <= cmd.opLo;
        else if (accept && (cmd.op == OP_LOAD_A) && regHit)
            acc_r <= regRdata;
        else if (state_r == ST_LOAD_WAIT)
            acc_r <= memRdata;
    end

    // index pointer updates
    always_ff @(posedge mclk)
    begin
        if (rst)
            index_r <= 12'h000;
        else if (accept && (cmd.op == OP_LOAD_X))
            index_r <= {cmd.opHi[3:0], cmd.opLo};
        else if (accept && (cmd.op == OP_INC_X))
            index_r <= {index_r[IDX_SEL_BIT], index_r[10:0] + 11'h001};
        else if (accept && (cmd.op == OP_DEC_X))
            index_r <= {index_r[IDX_SEL_BIT], index_r[10:0] - 11'h001};
        else if (storeReg && (ea == ADR_IDX_HI))
            index_r[11:8] <= acc_r[3:0];
        else if (storeReg && (ea == ADR_IDX_LO))
            index_r[7:0] <= acc_r;
    end

    // stack index
    always_ff @(posedge mclk)
    begin
        if (rst)
            stackTop_r <= STK_RST;
        else if (storeReg && (ea == ADR_STK_TOP))
            stackTop_r <= acc_r[3:0];
        else if (state_r == ST_PUSH_HI)
            stackTop_r <= stackTop_r - STK_STEP;
        else if (state_r == ST_PULL_LO)
            stackTop_r <= stackTop_r + STK_STEP;
    end

    // condition flags byte, reachable by mapped stores
    always_ff @(posedge mclk)
    begin
        if (rst)
            condFlags_r <= 8'h00;
        else if (storeReg && (ea == ADR_FLAGS))
            condFlags_r <= acc_r;
    end

    // return address holding
    always_ff @(posedge mclk)
    begin
        if (rst)
            retHold_r <= 11'h000;
        else if (accept && (cmd.op == OP_CALL))
            retHold_r <= seqPc;
        else if (state_r == ST_PULL_HI)
            retHold_r[10:8] <= memRdata[2:0];
    end

    // program counter
    always_ff @(posedge mclk)
    begin
        if (rst)
            nextInstPtr_r <= PC_RST_ADDR;
        else if (accept && ((cmd.op == OP_LONG_JUMP) || (cmd.op == OP_CALL)))
            nextInstPtr_r <= {1'b1, absTarget};
        else if (accept && (cmd.op == OP_SHORT_JUMP) && relOk)
            nextInstPtr_r <= {1'b1, relPc};
        else if (accept && (cmd.op != OP_RETURN))
            nextInstPtr_r <= {1'b1, seqPc};
        else if (state_r == ST_PULL_LO)
            nextInstPtr_r <= {1'b1, retHold_r[10:8], memRdata};
    end

    assign memReq       = memReq_r;
    assign busy         = busy_r;
    assign accOut       = acc_r;
    assign indexOut     = index_r;
    assign nextInstAddr = nextInstPtr_r;
    assign stackTopIdx  = stackTop_r;
    assign condFlagsOut = condFlags_r;

    // checks
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_call_take;
        accept && (cmd.op == OP_CALL);
    endsequence
    sequence s_ret_take;
        accept && (cmd.op == OP_RETURN);
    endsequence

    a_pc_reset: assert property ($past(rst) |-> nextInstPtr_r == PC_RST_ADDR)
        else $error("program counter not at reset address");
    a_stk_reset: assert property ($past(rst) |-> stackTop_r == STK_RST)
        else $error("stack index not at reset value");
    a_code_nowrite: assert property (memReq_r.we |-> !memReq_r.addr[IDX_SEL_BIT])
        else $error("write reached program space");
    a_stack_page: assert property ((state_r == ST_PUSH_HI) |-> memReq_r.addr[11:4] == {4'h0, STK_PAGE})
        else $error("stack access outside stack page");
    a_call_push: assert property (@(posedge mclk) disable iff (rst)
        s_call_take |=> memReq_r.we && (memReq_r.addr == stkAddr($past(stackTop_r)))
        ##1 memReq_r.we && (memReq_r.addr == stkAddr($past(stackTop_r, 2) - 4'h1))
        ##1 (stackTop_r == $past(stackTop_r, 2) - STK_STEP))
        else $error("call push order or step wrong");
    a_ret_pull: assert property (s_ret_take |=> memReq_r.re ##1 memReq_r.re ##1
        (stackTop_r == $past(stackTop_r, 3) + STK_STEP) && !busy_r)
        else $error("return pull sequence wrong");
    a_idx_keep: assert property (accept && (cmd.op == OP_INC_X)
        |=> index_r[IDX_SEL_BIT] == $past(index_r[IDX_SEL_BIT]))
        else $error("counting changed the select bit");
    a_load_imm: assert property (accept && (cmd.op == OP_LOAD_A) && (cmd.mode == MODE_IMMEDIATE)
        |=> acc_r == $past(cmd.opLo))
        else $error("immediate load lost");
    a_long_jump: assert property (accept && (cmd.op == OP_LONG_JUMP)
        |=> nextInstPtr_r == {1'b1, $past(cmd.opHi[2:0]), $past(cmd.opLo)})
        else $error("long jump target wrong");
endmodule : cra_core_regs

//--- cra_core_regs_note_unused.sv
// holds no logic; the whole core sits in one design file

//--- cra_mem_model.sv
// behavioural data and program memory seen by the core
`timescale 1ns/1ps
module cra_mem_model
    import cra_pkg::*;
(
    input  wire logic     mclk,
    input  wire cra_mem_s memReq,
    output logic [7:0]    memRdata
);
    logic [7:0] mem [0:4095];
    logic [7:0] drift;

    // preload each byte with a value tied to its address
    initial
    begin
        drift = 8'h5A;
        for (int i = 0; i < 4096; i++)
            mem[i] = 8'(i * 7 + 3);
    end

    // writes land on the rising edge; drift keeps an idle bus from looking stable
    always @(posedge mclk)
    begin
        if (memReq.we === 1'b1)
            mem[memReq.addr] <= memReq.wdata;
        drift <= drift + 8'h3B;
    end

    // read data valid only while the read strobe is up
    assign memRdata = memReq.re ? mem[memReq.addr] : drift;
endmodule : cra_mem_model

//--- cra_core_regs_tb.sv
// self-checking bench for the core register set
`timescale 1ns/1ps
module cra_core_regs_tb
    import cra_pkg::*;
;
    logic        mclk = 1'b0;
    logic        rst  = 1'b1;
    cra_cmd_s    cmd  = '0;
    logic [7:0]  memRdata;
    cra_mem_s    memReq;
    logic        busy;
    logic [7:0]  accOut;
    logic [11:0] indexOut;
    logic [11:0] nextInstAddr;
    logic [3:0]  stackTopIdx;
    logic [7:0]  condFlagsOut;
    int          error_cnt = 0;
    int          tests_run = 0;
    int          seed      = 89770;
    logic [11:0] expPc;
    logic [11:0] basePc;
    logic [3:0]  expSp;
    logic [7:0]  rv;
    logic [11:0] retQ [$];

    always #10 mclk = ~mclk;

    cra_core_regs cra_core_regs_i (.mclk(mclk), .rst(rst), .cmd(cmd), .memRdata(memRdata), .memReq(memReq),
        .busy(busy), .accOut(accOut), .indexOut(indexOut), .nextInstAddr(nextInstAddr),
        .stackTopIdx(stackTopIdx), .condFlagsOut(condFlagsOut));
    cra_mem_model cra_mem_model_i (.mclk(mclk), .memReq(memReq), .memRdata(memRdata));

    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        tests_run++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    // preload value of a byte that no store has touched
    function automatic logic [7:0] mem_init(input logic [11:0] a);
        mem_init = 8'(int'(a) * 7 + 3);
    endfunction : mem_init

    task automatic wrap_up;
        $display("comparisons %0d, mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask : wrap_up

    // present one command for one cycle; returns at the negedge of cycle+1
    task automatic issue(input cra_op_e op, input cra_mode_e md, input logic [1:0] ln, input logic [7:0] hi,
        input logic [7:0] lo);
        @(negedge mclk);
        cmd = {1'b1, op, md, ln, hi, lo};
        @(negedge mclk);
        cmd.valid = 1'b0;
        expPc = {1'b1, expPc[10:0] + 11'(ln)};
    endtask : issue

    // memory load: one read strobe at the formed address, then the byte lands in acc
    task automatic load_mem(input cra_mode_e md, input logic [7:0] lo, input logic [11:0] ea, input logic [7:0] eb);
        issue(OP_LOAD_A, md, 2'h2, 8'h00, lo);
        check({11'h0, memReq.re}, 12'h001);
        check({11'h0, busy}, 12'h001);
        check(memReq.addr, ea);
        @(negedge mclk);
        check({4'h0, accOut}, {4'h0, eb});
        check({11'h0, busy}, 12'h000);
    endtask : load_mem

    // subroutine call: two pushes, low byte first, stack index drops by two
    task automatic do_call(input logic [7:0] hi, input logic [7:0] lo);
        logic [11:0] ret;
        issue(OP_CALL, MODE_INHERENT, 2'h3, hi, lo);
        ret = expPc;
        retQ.push_back(ret);
        expPc = {1'b1, hi[2:0], lo};
        check({11'h0, memReq.we}, 12'h001);
        check(memReq.addr, {4'h0, STK_PAGE, expSp});
        check({4'h0, memReq.wdata}, {4'h0, ret[7:0]});
        check(nextInstAddr, expPc);
        check({11'h0, busy}, 12'h001);
        @(negedge mclk);
        check({11'h0, memReq.we}, 12'h001);
        check(memReq.addr, {4'h0, STK_PAGE, expSp - 4'h1});
        check({4'h0, memReq.wdata}, {9'h0, ret[10:8]});
        @(negedge mclk);
        expSp = expSp - STK_STEP;
        check({8'h0, stackTopIdx}, {8'h0, expSp});
    endtask : do_call

    // return: pull in reverse order and restore the program counter
    task automatic do_ret;
        issue(OP_RETURN, MODE_INHERENT, 2'h1, 8'h00, 8'h00);
        check({11'h0, memReq.re}, 12'h001);
        check(memReq.addr, {4'h0, STK_PAGE, expSp + 4'h1});
        @(negedge mclk);
        check({10'h0, busy, memReq.re}, 12'h003);
        check(memReq.addr, {4'h0, STK_PAGE, expSp + 4'h2});
        @(negedge mclk);
        expSp = expSp + STK_STEP;
        expPc = retQ.pop_back();
        check(nextInstAddr, expPc);
        check({8'h0, stackTopIdx}, {8'h0, expSp});
        check({10'h0, busy, memReq.re}, 12'h000);
    endtask : do_ret

    // watchdog cuts a hang short
    initial
    begin
        #(20 * 4000);
        error_cnt++;
        wrap_up();
    end

    // main sequence
    initial
    begin
        repeat (16) @(posedge mclk);
        @(negedge mclk);
        rst = 1'b0;
        expPc = PC_RST_ADDR;
        expSp = STK_RST;
        check(nextInstAddr, 12'h800);
        check({8'h0, stackTopIdx}, 12'h00F);
        check({10'h0, memReq.re, memReq.we}, 12'h000);
        check({11'h0, busy}, 12'h000);
        $display("reset values done");
        for (int i = 0; i < 4; i++)
        begin
            rv = 8'($random(seed));
            issue(OP_LOAD_A, MODE_IMMEDIATE, 2'h2, ~rv, rv);
            check({4'h0, accOut}, {4'h0, rv});
            check(nextInstAddr, expPc);
        end
        issue(OP_NOP, MODE_INHERENT, 2'h1, 8'hFF, 8'h77);
        check({4'h0, accOut}, {4'h0, rv});
        check(nextInstAddr, expPc);
        $display("immediate and inherent done");
        issue(OP_LOAD_X, MODE_IMMEDIATE, 2'h3, 8'h0F, 8'hFF);
        check(indexOut, 12'hFFF);
        issue(OP_INC_X, MODE_INHERENT, 2'h1, 8'h00, 8'h00);
        check(indexOut, 12'h800);
        issue(OP_DEC_X, MODE_INHERENT, 2'h1, 8'h00, 8'h00);
        check(indexOut, 12'hFFF);
        issue(OP_LOAD_A, MODE_IMMEDIATE, 2'h2, 8'h00, 8'h0D);
        issue(OP_STORE_A, MODE_DIRECT, 2'h2, 8'h00, 8'hBE);
        check({11'h0, memReq.we}, 12'h000);
        check(indexOut, 12'hDFF);
        issue(OP_LOAD_A, MODE_DIRECT, 2'h2, 8'h00, 8'hBE);
        check({4'h0, accOut}, 12'h005);
        rv = 8'($random(seed));
        issue(OP_LOAD_A, MODE_IMMEDIATE, 2'h2, 8'h00, rv);
        issue(OP_STORE_A, MODE_DIRECT, 2'h2, 8'h00, 8'hBF);
        check(indexOut, {4'hD, rv});
        $display("index pointer done");
        issue(OP_LOAD_X, MODE_IMMEDIATE, 2'h3, 8'h0F, 8'hF0);
        load_mem(MODE_INDEXED, 8'h20, 12'h810, mem_init(12'h810));
        issue(OP_STORE_A, MODE_INDEXED, 2'h2, 8'h00, 8'h05);
        check({11'h0, memReq.we}, 12'h000);
        rv = 8'($random(seed)) & 8'h7F;
        load_mem(MODE_DIRECT, rv, {4'h0, rv}, mem_init({4'h0, rv}));
        issue(OP_LOAD_X, MODE_IMMEDIATE, 2'h3, 8'h00, rv);
        load_mem(MODE_INDIRECT, 8'h99, {4'h0, rv}, mem_init({4'h0, rv}));
        rv = mem_init({4'h0, rv});
        issue(OP_STORE_A, MODE_DIRECT, 2'h2, 8'h00, 8'h44);
        check({11'h0, memReq.we}, 12'h001);
        check(memReq.addr, 12'h044);
        check({4'h0, memReq.wdata}, {4'h0, rv});
        issue(OP_LOAD_A, MODE_IMMEDIATE, 2'h2, 8'h00, ~rv);
        load_mem(MODE_DIRECT, 8'h44, 12'h044, rv);
        $display("memory access done");
        rv = 8'($random(seed));
        issue(OP_LOAD_A, MODE_IMMEDIATE, 2'h2, 8'h00, rv);
        issue(OP_STORE_A, MODE_DIRECT, 2'h2, 8'h00, 8'hFF);
        check({4'h0, condFlagsOut}, {4'h0, rv});
        issue(OP_LOAD_A, MODE_IMMEDIATE, 2'h2, 8'h00, 8'h09);
        issue(OP_STORE_A, MODE_DIRECT, 2'h2, 8'h00, 8'hFE);
        check({8'h0, stackTopIdx}, 12'h009);
        issue(OP_LOAD_A, MODE_DIRECT, 2'h2, 8'h00, 8'hFF);
        check({4'h0, accOut}, {4'h0, rv});
        issue(OP_LOAD_A, MODE_DIRECT, 2'h2, 8'h00, 8'hFE);
        check({4'h0, accOut}, 12'h009);
        expSp = 4'h9;
        $display("mapped registers done");
        do_call(8'h02, 8'h40);
        do_call(8'h06, 8'h18);
        do_ret();
        do_ret();
        $display("call and return done");
        @(negedge mclk);
        rst = 1'b1;
        repeat (2) @(negedge mclk);
        rst = 1'b0;
        check(nextInstAddr, 12'h800);
        check({8'h0, stackTopIdx}, 12'h00F);
        check(indexOut, 12'h000);
        check({4'h0, condFlagsOut}, 12'h000);
        expPc = PC_RST_ADDR;
        expSp = STK_RST;
        do_call(8'h01, 8'h55);
        do_ret();
        $display("second reset done");
        issue(OP_SHORT_JUMP, MODE_INHERENT, 2'h1, 8'h00, 8'h21);
        check(nextInstAddr, expPc);
        issue(OP_SHORT_JUMP, MODE_INHERENT, 2'h1, 8'h00, 8'hE0);
        check(nextInstAddr, expPc);
        basePc = expPc;
        issue(OP_SHORT_JUMP, MODE_INHERENT, 2'h1, 8'h00, 8'h20);
        expPc = {1'b1, basePc[10:0] + 11'h020};
        check(nextInstAddr, expPc);
        basePc = expPc;
        issue(OP_SHORT_JUMP, MODE_INHERENT, 2'h1, 8'h00, 8'hE1);
        expPc = {1'b1, basePc[10:0] - 11'h01F};
        check(nextInstAddr, expPc);
        issue(OP_LONG_JUMP, MODE_INHERENT, 2'h3, 8'h05, 8'h3C);
        check(nextInstAddr, 12'hD3C);
        $display("jumps done");
        wrap_up();
    end
endmodule : cra_core_regs_tb
